// ### core/card_status_pkg.sv
// Constants and types for the card status word block
package card_status_pkg;
  localparam int BIT_ARG_RANGE = 31;
  localparam int BIT_MISALIGN = 30;
  localparam int BIT_BLK_SIZE = 29;
  localparam int BIT_WIPE_ORDER = 28;
  localparam int BIT_WIPE_SELECT = 27;
  localparam int BIT_PROT_PROGRAM = 26;
  localparam int BIT_LOCKED = 25;
  localparam int BIT_LOCK_FAULT = 24;
  localparam int BIT_CRC_FAULT = 23;
  localparam int BIT_NOT_ALLOWED = 22;
  localparam int BIT_ECC_FAULT = 21;
  localparam int BIT_CTRL_FAULT = 20;
  localparam int BIT_GENERAL = 19;
  localparam int BIT_ID_REWRITE = 16;
  localparam int BIT_WIPE_SKIP = 15;
  localparam int BIT_ECC_BYPASS = 14;
  localparam int BIT_WIPE_ABANDON = 13;
  localparam int STATE_LSB = 9;
  localparam int BIT_READY_DATA = 8;
  localparam int BIT_APP_SPECIFIC_EXPECTED = 5;
  localparam int BIT_AUTH_ORDER = 3;
  // Clear-on-read, previous-command and defined-bit masks
  localparam logic [31:0] READ_CLEAR_MASK = 32'hFD39_A028;
  localparam logic [31:0] PREV_CMD_MASK = 32'h00C0_0000;
  localparam logic [31:0] DEFINED_MASK = 32'hFFF9_FF28;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_READY = 4'h1, ST_IDENT = 4'h2, ST_STANDBY = 4'h3,
    ST_TRANSFER = 4'h4, ST_DATA = 4'h5, ST_RECEIVE = 4'h6,
    ST_PROGRAM = 4'h7, ST_DISCONNECT = 4'h8
  } card_state_type;

  typedef struct packed {
    logic arg_range_fault;
    logic wipe_select_fault;
    logic protected_program_fault;
    logic lock_fault;
    logic ecc_fault;
    logic controller_fault;
    logic general_fault;
    logic id_reg_rewrite_fault;
    logic wipe_skip;
  } exec_events_type;

  typedef struct packed {
    logic cmd_valid;
    logic crc_fault;
    logic cmd_not_allowed;
    logic misalign_fault;
    logic blk_size_fault;
    logic wipe_order_fault;
    logic wipe_abandoned;
    logic app_specific_expected;
    logic auth_order_fault;
  } resp_events_type;

  typedef struct packed {
    logic locked_flag;
    logic ecc_bypassed;
    logic ready_for_data;
    card_state_type card_state;
  } card_cond_type;
endpackage

// ### core/card_status_word_logic.sv
// Card status word: sticky flags, state snapshot and link hand-off
`timescale 1ns/10ps
module card_status_word_logic (
  input wire logic core_clk, // Card core clock
  input wire logic reset_n, // Async reset, core domain
  input wire logic link_clk, // Card bus clock
  input wire logic link_reset_n, // Async reset, link domain
  input card_status_pkg::exec_events_type exec_events, // Execution event pulses
  input wire logic cmd_taken, // Command received pulse, core domain
  input card_status_pkg::resp_events_type resp_events, // Qualified by cmd_taken
  input card_status_pkg::card_cond_type card_cond, // Live card condition
  input wire logic resp_start, // Link: response begins, pulse
  input wire logic resp_done, // Link: status word fully sent, pulse
  output logic [31:0] status_word, // Link: word to send
  output logic word_ready // Link: status_word is valid
);
  import card_status_pkg::*;

  typedef struct packed {
    logic [31:0] sticky;
    logic [31:0] prev_cmd;
    card_state_type state_field;
    logic [31:0] hold;
    logic ack_tog;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic done_s1;
    logic done_s2;
    logic done_seen;
  } core_state_type;

  typedef struct packed {
    logic req_tog;
    logic done_tog;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic [31:0] word;
    logic ready;
  } link_state_type;

  core_state_type cs, next_cs;
  link_state_type ls, next_ls;
  logic [31:0] set_now;
  logic [31:0] live_word;

  // ==========================================================
  // Core domain: event capture and word assembly
  // ==========================================================
  function automatic logic [31:0] place(input int pos, input logic val);
    logic [31:0] v;
    v = '0;
    v[pos] = val;
    return v;
  endfunction

  always_comb begin
    set_now = '0;
    // Execution events land whenever the core raises them
    set_now |= place(BIT_ARG_RANGE, exec_events.arg_range_fault);
    set_now |= place(BIT_WIPE_SELECT, exec_events.wipe_select_fault);
    set_now |= place(BIT_PROT_PROGRAM, exec_events.protected_program_fault);
    set_now |= place(BIT_LOCK_FAULT, exec_events.lock_fault);
    set_now |= place(BIT_ECC_FAULT, exec_events.ecc_fault);
    set_now |= place(BIT_CTRL_FAULT, exec_events.controller_fault);
    set_now |= place(BIT_GENERAL, exec_events.general_fault);
    set_now |= place(BIT_ID_REWRITE, exec_events.id_reg_rewrite_fault);
    set_now |= place(BIT_WIPE_SKIP, exec_events.wipe_skip);
    if (cmd_taken) begin
      // Response-detected bits belong to the command being answered
      set_now |= place(BIT_MISALIGN, resp_events.misalign_fault);
      set_now |= place(BIT_BLK_SIZE, resp_events.blk_size_fault);
      set_now |= place(BIT_WIPE_ORDER, resp_events.wipe_order_fault);
      set_now |= place(BIT_WIPE_ABANDON, resp_events.wipe_abandoned);
      set_now |= place(BIT_APP_SPECIFIC_EXPECTED, resp_events.app_specific_expected);
      set_now |= place(BIT_AUTH_ORDER, resp_events.auth_order_fault);
    end
  end

  always_comb begin
    live_word = cs.sticky | cs.prev_cmd;
    // Condition bits other than the state are never latched, read straight from the core
    live_word |= place(BIT_LOCKED, card_cond.locked_flag);
    live_word |= place(BIT_ECC_BYPASS, card_cond.ecc_bypassed);
    live_word |= place(BIT_READY_DATA, card_cond.ready_for_data);
    live_word[STATE_LSB +: 4] = cs.state_field;
    live_word &= DEFINED_MASK;
  end

  always_comb begin
    next_cs = cs;
    next_cs.req_s1 = ls.req_tog;
    next_cs.req_s2 = cs.req_s1;
    next_cs.done_s1 = ls.done_tog;
    next_cs.done_s2 = cs.done_s1;
    next_cs.sticky = cs.sticky | (set_now & READ_CLEAR_MASK);
    if (cs.done_s2 != cs.done_seen) begin
      next_cs.done_seen = cs.done_s2;
      // Only bits the host has seen are dropped; a same-cycle set survives
      next_cs.sticky = (cs.sticky & ~(cs.hold & READ_CLEAR_MASK))
        | (set_now & READ_CLEAR_MASK);
    end
    if (cmd_taken) begin
      // State as found on receipt; the command's own move shows next time
      next_cs.state_field = card_cond.card_state;
      if (resp_events.cmd_valid) begin
        // Valid command replaces the old flags, so they clear one command late
        next_cs.prev_cmd = '0;
      end
      next_cs.prev_cmd |= place(BIT_CRC_FAULT, resp_events.crc_fault);
      next_cs.prev_cmd |= place(BIT_NOT_ALLOWED, resp_events.cmd_not_allowed);
      if (!resp_events.cmd_valid) begin
        next_cs.prev_cmd |= cs.prev_cmd;
      end
    end
    if (cs.req_s2 != cs.req_seen) begin
      // Snapshot held stable for the link until the next request
      next_cs.req_seen = cs.req_s2;
      next_cs.hold = live_word;
      next_cs.ack_tog = ~cs.ack_tog;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs <= '{sticky: WORD_RESET, prev_cmd: WORD_RESET, state_field: ST_IDLE,
             hold: WORD_RESET, default: 1'b0};
    end else begin
      cs <= next_cs;
    end
  end

  // ==========================================================
  // Link domain: request, take the word, report it sent
  // ==========================================================
  always_comb begin
    next_ls = ls;
    next_ls.ack_s1 = cs.ack_tog;
    next_ls.ack_s2 = ls.ack_s1;
    if (resp_start) begin
      next_ls.req_tog = ~ls.req_tog;
      next_ls.ready = 1'b0;
    end
    if (ls.ack_s2 != ls.ack_seen) begin
      // Hold is stable here: the core only changes it on a new request
      next_ls.ack_seen = ls.ack_s2;
      next_ls.word = cs.hold;
      next_ls.ready = 1'b1;
    end
    if (resp_done) begin
      next_ls.done_tog = ~ls.done_tog;
    end
  end

  always_ff @(posedge link_clk or negedge link_reset_n) begin
    if (!link_reset_n) begin
      ls <= '{word: WORD_RESET, default: 1'b0};
    end else begin
      ls <= next_ls;
    end
  end

  assign status_word = ls.word;
  assign word_ready = ls.ready;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_exec_hold;
    @(posedge core_clk) disable iff (!reset_n)
      (exec_events.arg_range_fault && cs.done_s2 == cs.done_seen)
      |=> cs.sticky[BIT_ARG_RANGE];
  endproperty
  a_exec_hold: assert property (p_exec_hold) else $error("range flag lost");

  property p_range_sticky;
    @(posedge core_clk) disable iff (!reset_n)
      (cs.sticky[BIT_ARG_RANGE] && cs.done_s2 == cs.done_seen)
      |=> cs.sticky[BIT_ARG_RANGE];
  endproperty
  a_range_sticky: assert property (p_range_sticky) else $error("range flag dropped");

  property p_resp_set;
    @(posedge core_clk) disable iff (!reset_n)
      (cmd_taken && resp_events.misalign_fault) |=> cs.sticky[BIT_MISALIGN];
  endproperty
  a_resp_set: assert property (p_resp_set) else $error("misalign not set");

  property p_set_wins;
    @(posedge core_clk) disable iff (!reset_n)
      (cs.done_s2 != cs.done_seen && exec_events.wipe_skip)
      |=> cs.sticky[BIT_WIPE_SKIP];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost on clear");

  property p_clear_read;
    @(posedge core_clk) disable iff (!reset_n)
      (cs.done_s2 != cs.done_seen && cs.hold[BIT_GENERAL] && !exec_events.general_fault)
      |=> !cs.sticky[BIT_GENERAL];
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("read clear failed");

  property p_prev_valid;
    @(posedge core_clk) disable iff (!reset_n)
      (cmd_taken && resp_events.cmd_valid && !resp_events.crc_fault
       && !resp_events.cmd_not_allowed) |=> cs.prev_cmd == WORD_RESET;
  endproperty
  a_prev_valid: assert property (p_prev_valid) else $error("prev flags kept");

  property p_crc_flag;
    @(posedge core_clk) disable iff (!reset_n)
      (cmd_taken && resp_events.crc_fault) |=> cs.prev_cmd[BIT_CRC_FAULT];
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc flag missing");

  property p_state_snap;
    @(posedge core_clk) disable iff (!reset_n)
      cmd_taken |=> cs.state_field == $past(card_cond.card_state);
  endproperty
  a_state_snap: assert property (p_state_snap) else $error("state not captured");

  property p_reserved;
    @(posedge link_clk) disable iff (!link_reset_n)
      word_ready |-> (status_word & ~DEFINED_MASK) == WORD_RESET;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_locked_live;
    @(posedge core_clk) disable iff (!reset_n)
      live_word[BIT_LOCKED] == card_cond.locked_flag
      && live_word[BIT_READY_DATA] == card_cond.ready_for_data;
  endproperty
  a_locked_live: assert property (p_locked_live) else $error("live bit wrong");

  property p_blk_size;
    @(posedge core_clk) disable iff (!reset_n)
      (cmd_taken && resp_events.blk_size_fault) |=> cs.sticky[BIT_BLK_SIZE];
  endproperty
  a_blk_size: assert property (p_blk_size) else $error("block size flag missing");

  property p_wipe_order;
    @(posedge core_clk) disable iff (!reset_n)
      (cmd_taken && resp_events.wipe_order_fault) |=> cs.sticky[BIT_WIPE_ORDER];
  endproperty
  a_wipe_order: assert property (p_wipe_order) else $error("wipe order flag missing");

  property p_wipe_abandon;
    @(posedge core_clk) disable iff (!reset_n)
      (cmd_taken && resp_events.wipe_abandoned) |=> cs.sticky[BIT_WIPE_ABANDON];
  endproperty
  a_wipe_abandon: assert property (p_wipe_abandon) else $error("abandon flag missing");

  property p_app_specific_expected;
    @(posedge core_clk) disable iff (!reset_n)
      (cmd_taken && resp_events.app_specific_expected) |=> cs.sticky[BIT_APP_SPECIFIC_EXPECTED];
  endproperty
  a_app_specific_expected: assert property (p_app_specific_expected) else $error("app command flag missing");

  property p_auth_order;
    @(posedge core_clk) disable iff (!reset_n)
      (cmd_taken && resp_events.auth_order_fault) |=> cs.sticky[BIT_AUTH_ORDER];
  endproperty
  a_auth_order: assert property (p_auth_order) else $error("auth order flag missing");

  property p_wipe_select;
    @(posedge core_clk) disable iff (!reset_n)
      exec_events.wipe_select_fault |=> cs.sticky[BIT_WIPE_SELECT];
  endproperty
  a_wipe_select: assert property (p_wipe_select) else $error("wipe select flag missing");

  property p_prot_program;
    @(posedge core_clk) disable iff (!reset_n)
      exec_events.protected_program_fault |=> cs.sticky[BIT_PROT_PROGRAM];
  endproperty
  a_prot_program: assert property (p_prot_program) else $error("protect flag missing");

  property p_lock_fault;
    @(posedge core_clk) disable iff (!reset_n)
      exec_events.lock_fault |=> cs.sticky[BIT_LOCK_FAULT];
  endproperty
  a_lock_fault: assert property (p_lock_fault) else $error("lock fault flag missing");

  property p_ecc_fault;
    @(posedge core_clk) disable iff (!reset_n)
      exec_events.ecc_fault |=> cs.sticky[BIT_ECC_FAULT];
  endproperty
  a_ecc_fault: assert property (p_ecc_fault) else $error("ecc fault flag missing");

  property p_ctrl_fault;
    @(posedge core_clk) disable iff (!reset_n)
      exec_events.controller_fault |=> cs.sticky[BIT_CTRL_FAULT];
  endproperty
  a_ctrl_fault: assert property (p_ctrl_fault) else $error("controller flag missing");

  property p_general_set;
    @(posedge core_clk) disable iff (!reset_n)
      exec_events.general_fault |=> cs.sticky[BIT_GENERAL];
  endproperty
  a_general_set: assert property (p_general_set) else $error("general flag missing");

  property p_id_rewrite;
    @(posedge core_clk) disable iff (!reset_n)
      exec_events.id_reg_rewrite_fault |=> cs.sticky[BIT_ID_REWRITE];
  endproperty
  a_id_rewrite: assert property (p_id_rewrite) else $error("rewrite flag missing");

  property p_wipe_skip;
    @(posedge core_clk) disable iff (!reset_n)
      exec_events.wipe_skip |=> cs.sticky[BIT_WIPE_SKIP];
  endproperty
  a_wipe_skip: assert property (p_wipe_skip) else $error("wipe skip flag missing");

  property p_not_allowed;
    @(posedge core_clk) disable iff (!reset_n)
      (cmd_taken && resp_events.cmd_not_allowed) |=> cs.prev_cmd[BIT_NOT_ALLOWED];
  endproperty
  a_not_allowed: assert property (p_not_allowed) else $error("illegal flag missing");

  property p_prev_kept;
    @(posedge core_clk) disable iff (!reset_n)
      (cmd_taken && !resp_events.cmd_valid)
      |=> (cs.prev_cmd & $past(cs.prev_cmd)) == $past(cs.prev_cmd);
  endproperty
  a_prev_kept: assert property (p_prev_kept) else $error("prev flags lost");

  property p_prev_not_read;
    @(posedge core_clk) disable iff (!reset_n)
      !cmd_taken |=> cs.prev_cmd == $past(cs.prev_cmd);
  endproperty
  a_prev_not_read: assert property (p_prev_not_read) else $error("prev flags moved");

  property p_state_hold;
    @(posedge core_clk) disable iff (!reset_n)
      !cmd_taken |=> $stable(cs.state_field);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("state moved early");

  property p_state_legal;
    @(posedge core_clk) disable iff (!reset_n)
      cs.state_field <= ST_DISCONNECT;
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("reserved state code");

  property p_cond_not_latched;
    @(posedge core_clk) disable iff (!reset_n)
      !cs.sticky[BIT_LOCKED] && !cs.sticky[BIT_ECC_BYPASS] && !cs.sticky[BIT_READY_DATA];
  endproperty
  a_cond_not_latched: assert property (p_cond_not_latched) else $error("live bit latched");

  property p_ecc_bypass_live;
    @(posedge core_clk) disable iff (!reset_n)
      live_word[BIT_ECC_BYPASS] == card_cond.ecc_bypassed;
  endproperty
  a_ecc_bypass_live: assert property (p_ecc_bypass_live) else $error("bypass bit wrong");

  property p_state_in_word;
    @(posedge core_clk) disable iff (!reset_n)
      live_word[STATE_LSB +: $bits(card_state_type)] == cs.state_field;
  endproperty
  a_state_in_word: assert property (p_state_in_word) else $error("state field wrong");

  property p_clear_only_sent;
    @(posedge core_clk) disable iff (!reset_n)
      (cs.sticky[BIT_GENERAL] && !cs.hold[BIT_GENERAL]) |=> cs.sticky[BIT_GENERAL];
  endproperty
  a_clear_only_sent: assert property (p_clear_only_sent) else $error("unsent flag cleared");

  property p_hold_stable;
    @(posedge core_clk) disable iff (!reset_n)
      (cs.req_s2 == cs.req_seen) |=> $stable(cs.hold);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("snapshot moved");

  property p_ready_drop;
    @(posedge link_clk) disable iff (!link_reset_n)
      resp_start |=> !word_ready;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("stale word offered");

  property p_word_stable;
    @(posedge link_clk) disable iff (!link_reset_n)
      (word_ready && !resp_start) |=> $stable(status_word);
  endproperty
  a_word_stable: assert property (p_word_stable) else $error("word changed while held");

  property p_word_arrives;
    @(posedge link_clk) disable iff (!link_reset_n)
      resp_start |=> ##[0:8] word_ready;
  endproperty
  a_word_arrives: assert property (p_word_arrives) else $error("word late");
endmodule // card_status_word_logic

// ### bench/host_model.sv
// Host-side model that polls the card status word over the link
`timescale 1ns/10ps
module host_model (
  input wire logic link_clk, // Card bus clock
  input wire logic [31:0] status_word, // Word from the card
  input wire logic word_ready, // Word valid
  output logic resp_start, // Response request pulse
  output logic resp_done // Word fully taken pulse
);
  initial begin
    resp_start = 1'b0;
    resp_done = 1'b0;
  end
  // ====================
  // Status poll; ok stays low if the card never answers
  task automatic poll(output logic [31:0] word, output logic ok);
    int n;
    ok = 1'b0;
    word = 32'h0000_0000;
    @(posedge link_clk);
    resp_start <= 1'b1;
    @(posedge link_clk);
    resp_start <= 1'b0;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge link_clk);
      if (word_ready === 1'b1) begin
        word = status_word;
        ok = 1'b1;
      end
    end
    if (ok) begin
      resp_done <= 1'b1;
      @(posedge link_clk);
      resp_done <= 1'b0;
    end
  endtask
endmodule // host_model

// ### bench/tb_top.sv
// Self-checking bench for the card status word
`timescale 1ns/10ps
`define check(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  import card_status_pkg::*;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n;
  exec_events_type exec_events;
  logic cmd_taken;
  resp_events_type resp_events;
  card_cond_type card_cond;
  logic resp_start;
  logic resp_done;
  logic word_ready;
  logic [31:0] status_word;
  int mismatches = 0;
  int num_checks = 0;
  logic [31:0] w;
  logic ok;
  int exec_pos [9] = '{15, 16, 19, 20, 21, 24, 26, 27, 31};
  int resp_pos [8] = '{3, 5, 13, 28, 29, 30, 22, 23};

  // Rising edges of the two clocks never coincide
  always #25 core_clk = ~core_clk;
  always #80 link_clk = ~link_clk;

  card_status_word_logic i_card_status_word_logic (
    .core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk), .link_reset_n(reset_n),
    .exec_events(exec_events), .cmd_taken(cmd_taken), .resp_events(resp_events),
    .card_cond(card_cond), .resp_start(resp_start), .resp_done(resp_done),
    .status_word(status_word), .word_ready(word_ready));

  host_model i_host_model (.link_clk(link_clk), .status_word(status_word),
    .word_ready(word_ready), .resp_start(resp_start), .resp_done(resp_done));

  // ====================
  // Helpers
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic read_word();
    i_host_model.poll(w, ok);
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: no status word", $time);
      give_verdict();
    end
  endtask

  task automatic command(input resp_events_type ev);
    @(posedge core_clk);
    resp_events <= ev;
    cmd_taken <= 1'b1;
    @(posedge core_clk);
    cmd_taken <= 1'b0;
    resp_events <= '0;
    repeat (2) @(posedge core_clk);
  endtask

  // ====================
  // Main sequence
  initial begin
    exec_events = '0;
    cmd_taken = 1'b0;
    resp_events = '0;
    card_cond = '0;
    reset_n = 1'b0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    read_word();
    `check(w, 32'h0000_0000)
    $display("test reset word done");
    for (int i = 0; i < 9; i++) begin
      @(posedge core_clk);
      exec_events <= exec_events_type'(9'h1 << i);
      @(posedge core_clk);
      exec_events <= '0;
      repeat (2) @(posedge core_clk);
      read_word();
      `check(w, 32'h1 << exec_pos[i])
      read_word();
      `check(w, 32'h0000_0000)
    end
    $display("test execution flags done");
    @(posedge core_clk);
    exec_events.wipe_skip <= 1'b1;
    repeat (2) @(posedge core_clk);
    read_word();
    `check(w, 32'h0000_8000)
    read_word();
    `check(w, 32'h0000_8000)
    @(posedge core_clk);
    exec_events <= '0;
    repeat (4) @(posedge core_clk);
    read_word();
    `check(w, 32'h0000_0000)
    $display("test set over clear done");
    for (int i = 0; i < 8; i++) begin
      command(resp_events_type'(9'h1 << i));
      read_word();
      `check(w, 32'h1 << resp_pos[i])
      read_word();
      `check(w, (i >= 6) ? 32'h1 << resp_pos[i] : 32'h0000_0000)
      command(resp_events_type'(9'h100));
      read_word();
      `check(w, 32'h0000_0000)
    end
    $display("test response flags done");
    for (int s = 0; s < 9; s++) begin
      @(posedge core_clk);
      card_cond <= '{locked_flag: s[0], ecc_bypassed: s[1], ready_for_data: !s[0],
                     card_state: card_state_type'(4'(s))};
      command(resp_events_type'(9'h100));
      card_cond.card_state <= card_state_type'(4'((s + 3) % 9));
      read_word();
      `check(w, ({6'h00, s[0], 10'h000, s[1], 1'b0, 4'(s), !s[0], 8'h00}))
    end
    $display("test state field done");
    give_verdict();
  end
endmodule // tb_top
